// >>> pkg/wblc_cfg.svh
`ifndef WBLC_CFG_SVH
`define WBLC_CFG_SVH

// clock and timing
`define WBLC_CLK_HZ          25000000
`define WBLC_CTRL_PERIOD_MS  50
`define WBLC_MS_PER_S        1000
`define WBLC_SEC_PER_MIN     60
`define WBLC_DLY_MAX         14'h270f

// sizes
`define WBLC_NUM_BITS        8
`define WBLC_NUM_EV          4
`define WBLC_ST_W            34
`define WBLC_NUM_AUX         2
`define WBLC_NUM_EVD         2

// input assignment codes
`define WBLC_SEL_OFF         6'h00
`define WBLC_SEL_ON          6'h01
`define WBLC_SEL_FIRST       6'h02
`define WBLC_SEL_EV_BASE     6'h03
`define WBLC_SEL_ST_BASE     6'h07
`define WBLC_SEL_RSVD        6'h23
`define WBLC_SEL_WB_BASE     6'h29
`define WBLC_SEL_WB_LAST     6'h30

// event input data codes
`define WBLC_EVD_EV_BASE     4'h1
`define WBLC_EVD_WB_BASE     4'h5
`define WBLC_EVD_WB_LAST     4'hc

// auxiliary routing codes: 0 none, 1..8 work bit
`define WBLC_AUX_WB_BASE     4'h1

`endif

// >>> pkg/wblc_pkg.sv
package wblc_pkg;

    typedef logic [5:0]  wblc_sel_t;
    typedef logic [2:0]  wblc_op_t;
    typedef logic [13:0] wblc_dly_t;
    typedef logic [3:0]  wblc_rsel_t;

    typedef enum logic [2:0] {
        WBLC_OP_NONE,
        WBLC_OP_ANDOR,
        WBLC_OP_ORAND,
        WBLC_OP_OR4,
        WBLC_OP_AND4
    } wblc_op_e;

endpackage : wblc_pkg

// >>> hdl/wblc_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "wblc_cfg.svh"

module wblc_delay
    import wblc_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ctl_tick_i,
    input  wire logic              unit_tick_i,
    input  wire logic              cond_i,
    input  wire wblc_pkg::wblc_dly_t on_dly_i,
    input  wire wblc_pkg::wblc_dly_t off_dly_i,
    output logic                   out_o
);

    typedef struct packed {
        logic      cond;
        logic      out;
        wblc_dly_t cnt;
    } wblc_dly_st_s;

    wblc_dly_st_s st_q;
    wblc_dly_st_s st_d;
    wblc_dly_t    dly_pend;
    wblc_dly_t    dly_new;

    assign out_o = st_q.out;

    always_comb
    begin
        st_d     = st_q;
        dly_pend = st_q.cond ? on_dly_i : off_dly_i;
        dly_new  = cond_i ? on_dly_i : off_dly_i;
        // time units accumulate only while a change is pending
        if (unit_tick_i && (st_q.cond != st_q.out) && (st_q.cnt < dly_pend))
        begin
            st_d.cnt = st_q.cnt + 14'h0001;
        end
        if (ctl_tick_i)
        begin
            st_d.cond = cond_i;
            if (cond_i == st_q.out)
            begin
                st_d.cnt = '0;
            end
            else if (cond_i != st_q.cond)
            begin
                st_d.cnt = '0; // RULE_16
                if (dly_new == '0)
                begin
                    st_d.out = cond_i;
                end
            end
            else if (st_d.cnt >= dly_new)
            begin
                st_d.out = cond_i; // RULE_13 RULE_14
                st_d.cnt = '0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule : wblc_delay
`default_nettype wire

// >>> hdl/wblc_top.sv
// Summary of operation
// RULE_01 - each selected status condition or event input is taken as a 1 or 0 and the combined result lands in its work bit.
// RULE_02 - each work bit can be routed to an auxiliary or control output and to the mode-changing event data.
// RULE_03 - there are eight work bits, each with its own operation type and its own four input conditions.
// RULE_04 - after reset every work bit is in no-operation and reads 0 whatever its inputs are.
// RULE_05 - a dot indicator is lit whenever any work bit has an active operation.
// RULE_06 - each work bit selects one of four operation types or no-operation.
// RULE_07 - operation 1 gives (A and B) or (C and D).
// RULE_08 - operation 2 gives (A or C) and (B or D).
// RULE_09 - operation 3 gives A or B or C or D.
// RULE_10 - operation 4 gives A and B and C and D.
// RULE_11 - assignment code 0 is always off, 1 always on, 2 on for the first control cycle after power-up.
// RULE_12 - each input A to D can be passed as is or inverted.
// RULE_13 - a nonzero ON delay holds off the rise until the true condition has lasted that long.
// RULE_14 - a nonzero OFF delay holds off the fall until the false condition has lasted that long.
// RULE_15 - all work bits are evaluated once per control cycle, a work bit used as input gives its previous value.
// RULE_16 - delays count seconds or minutes by one unit setting and restart when the condition changes early.
`timescale 1ns/1ps
`default_nettype none
`include "wblc_cfg.svh"

module wblc_top
    import wblc_pkg::*;
#(
    parameter int unsigned NB          = `WBLC_NUM_BITS,
    parameter int unsigned NAUX        = `WBLC_NUM_AUX,
    parameter int unsigned NEVD        = `WBLC_NUM_EVD,
    parameter int unsigned CTRL_CYCLES = (`WBLC_CLK_HZ / `WBLC_MS_PER_S) * `WBLC_CTRL_PERIOD_MS,
    parameter int unsigned SEC_CYCLES  = `WBLC_CLK_HZ
)
(
    input  wire logic                              mclk_i,
    input  wire logic                              rst_n_i,
    input  wire logic [`WBLC_NUM_EV-1:0]           event_i,
    input  wire logic [`WBLC_ST_W-1:0]             status_i,
    input  wire wblc_pkg::wblc_op_t  [NB-1:0]      op_type_i,
    input  wire wblc_pkg::wblc_sel_t [NB-1:0][3:0] in_sel_i,
    input  wire logic [NB-1:0][3:0]                in_inv_i,
    input  wire logic [NB-1:0]                     out_inv_i,
    input  wire wblc_pkg::wblc_dly_t [NB-1:0]      on_dly_i,
    input  wire wblc_pkg::wblc_dly_t [NB-1:0]      off_dly_i,
    input  wire logic                              unit_min_i,
    input  wire wblc_pkg::wblc_rsel_t [NAUX-1:0]   aux_sel_i,
    input  wire wblc_pkg::wblc_rsel_t [NEVD-1:0]   evd_sel_i,
    output logic [NB-1:0]                          work_bit_o,
    output logic [NAUX-1:0]                        aux_o,
    output logic [NEVD-1:0]                        evd_o,
    output logic                                   dot_o,
    output logic                                   ctl_tick_o
);

    localparam int unsigned CW = (CTRL_CYCLES > 1) ? $clog2(CTRL_CYCLES) : 1;
    localparam int unsigned SW = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;

    typedef struct packed {
        logic [`WBLC_NUM_EV-1:0] ev_m;
        logic [`WBLC_NUM_EV-1:0] ev_s;
        logic [CW-1:0]           cyc_cnt;
        logic [SW-1:0]           sec_cnt;
        logic [5:0]              min_cnt;
        logic                    first;
        logic                    tick;
        logic [NB-1:0]           wb;
        logic [NAUX-1:0]         aux;
        logic [NEVD-1:0]         evd;
        logic                    dot;
    } wblc_top_st_s;

    localparam wblc_top_st_s ST_RST = '{first: 1'b1, default: '0};

    wblc_top_st_s st_q;
    wblc_top_st_s st_d;
    logic         ctl_tick;
    logic         sec_tick;
    logic         min_tick;
    logic         unit_tick;
    logic [NB-1:0] cond;
    logic [NB-1:0] dly_out;

    // one condition per assignment code
    function automatic logic sel_cond(
        input wblc_sel_t               code,
        input logic                    first,
        input logic [`WBLC_NUM_EV-1:0] ev,
        input logic [`WBLC_ST_W-1:0]   st,
        input logic [NB-1:0]           wb
    );
        logic r;
        r = 1'b0;
        if (code == `WBLC_SEL_ON)
        begin
            r = 1'b1;
        end
        else if (code == `WBLC_SEL_FIRST)
        begin
            r = first;
        end
        else if ((code >= `WBLC_SEL_EV_BASE) && (code < `WBLC_SEL_ST_BASE))
        begin
            r = ev[2'(code - `WBLC_SEL_EV_BASE)];
        end
        else if ((code >= `WBLC_SEL_ST_BASE) && (code < `WBLC_SEL_WB_BASE) && (code != `WBLC_SEL_RSVD))
        begin
            r = st[6'(code - `WBLC_SEL_ST_BASE)];
        end
        else if ((code >= `WBLC_SEL_WB_BASE) && (code <= `WBLC_SEL_WB_LAST))
        begin
            r = wb[3'(code - `WBLC_SEL_WB_BASE)];
        end
        return r;
    endfunction : sel_cond

    // combines the four conditions by operation type
    function automatic logic combine(input wblc_op_t op, input logic [3:0] c);
        logic r;
        r = 1'b0;
        case (wblc_op_e'(op))
            WBLC_OP_ANDOR: r = (c[0] & c[1]) | (c[2] & c[3]); // RULE_07
            WBLC_OP_ORAND: r = (c[0] | c[2]) & (c[1] | c[3]); // RULE_08
            WBLC_OP_OR4:   r = |c; // RULE_09
            WBLC_OP_AND4:  r = &c; // RULE_10
            default:       r = 1'b0; // RULE_04
        endcase
        return r;
    endfunction : combine

    function automatic logic op_active(input wblc_op_t op);
        return (op >= 3'(WBLC_OP_ANDOR)) && (op <= 3'(WBLC_OP_AND4));
    endfunction : op_active

    assign ctl_tick   = (st_q.cyc_cnt == CW'(CTRL_CYCLES - 1));
    assign sec_tick   = (st_q.sec_cnt == SW'(SEC_CYCLES - 1));
    assign min_tick   = sec_tick && (st_q.min_cnt == 6'(`WBLC_SEC_PER_MIN - 1));
    assign unit_tick  = unit_min_i ? min_tick : sec_tick; // RULE_16
    assign work_bit_o = st_q.wb;
    assign aux_o      = st_q.aux;
    assign evd_o      = st_q.evd;
    assign dot_o      = st_q.dot;
    assign ctl_tick_o = st_q.tick;

    always_comb
    begin
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < NB; i++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                // work bit feedback reads the registered value of the last cycle
                c[j] = sel_cond(in_sel_i[i][j], st_q.first, st_q.ev_s, status_i, st_q.wb) // RULE_01 RULE_11 RULE_15
                       ^ in_inv_i[i][j]; // RULE_12
            end
            cond[i] = op_active(op_type_i[i]) & (combine(op_type_i[i], c) ^ out_inv_i[i]); // RULE_06
        end
    end

    generate
        for (genvar g = 0; g < NB; g++)
        begin : g_bit
            wblc_delay u_delay (
                .mclk_i      (mclk_i),
                .rst_n_i     (rst_n_i),
                .ctl_tick_i  (ctl_tick),
                .unit_tick_i (unit_tick),
                .cond_i      (cond[g]),
                .on_dly_i    (on_dly_i[g]),
                .off_dly_i   (off_dly_i[g]),
                .out_o       (dly_out[g])
            ); // RULE_03
        end
    endgenerate

    always_comb
    begin
        st_d      = st_q;
        st_d.ev_m = event_i;
        st_d.ev_s = st_q.ev_m;
        st_d.tick = ctl_tick;
        st_d.cyc_cnt = ctl_tick ? '0 : CW'(st_q.cyc_cnt + 1'b1); // RULE_15
        st_d.sec_cnt = sec_tick ? '0 : SW'(st_q.sec_cnt + 1'b1);
        if (min_tick)
        begin
            st_d.min_cnt = '0;
        end
        else if (sec_tick)
        begin
            st_d.min_cnt = st_q.min_cnt + 6'h01;
        end
        if (ctl_tick)
        begin
            st_d.first = 1'b0; // RULE_11
        end
        st_d.dot = 1'b0;
        for (int i = 0; i < NB; i++)
        begin
            st_d.wb[i] = dly_out[i] & op_active(op_type_i[i]); // RULE_04
            st_d.dot   = st_d.dot | op_active(op_type_i[i]); // RULE_05
        end
        for (int k = 0; k < NAUX; k++)
        begin
            st_d.aux[k] = (aux_sel_i[k] >= `WBLC_AUX_WB_BASE) && (aux_sel_i[k] < 4'(NB + 1))
                          && st_q.wb[3'(aux_sel_i[k] - `WBLC_AUX_WB_BASE)]; // RULE_02
        end
        for (int k = 0; k < NEVD; k++)
        begin
            st_d.evd[k] = 1'b0;
            if ((evd_sel_i[k] >= `WBLC_EVD_EV_BASE) && (evd_sel_i[k] < `WBLC_EVD_WB_BASE))
            begin
                st_d.evd[k] = st_q.ev_s[2'(evd_sel_i[k] - `WBLC_EVD_EV_BASE)];
            end
            else if ((evd_sel_i[k] >= `WBLC_EVD_WB_BASE) && (evd_sel_i[k] <= `WBLC_EVD_WB_LAST))
            begin
                st_d.evd[k] = st_q.wb[3'(evd_sel_i[k] - `WBLC_EVD_WB_BASE)]; // RULE_02
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= ST_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule : wblc_top
`default_nettype wire

// >>> verification/wblc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "wblc_cfg.svh"

module wblc_props
    import wblc_pkg::*;
#(parameter int unsigned NB = 8, NAUX = 2, NEVD = 2, CTRL_CYCLES = 8, SEC_CYCLES = 20)
(
    input wire logic                              mclk_i,
    input wire logic                              rst_n_i,
    input wire logic [`WBLC_NUM_EV-1:0]           event_i,
    input wire logic [`WBLC_ST_W-1:0]             status_i,
    input wire wblc_pkg::wblc_op_t  [NB-1:0]      op_type_i,
    input wire wblc_pkg::wblc_sel_t [NB-1:0][3:0] in_sel_i,
    input wire logic [NB-1:0][3:0]                in_inv_i,
    input wire logic [NB-1:0]                     out_inv_i,
    input wire wblc_pkg::wblc_dly_t [NB-1:0]      on_dly_i,
    input wire wblc_pkg::wblc_dly_t [NB-1:0]      off_dly_i,
    input wire logic                              unit_min_i,
    input wire wblc_pkg::wblc_rsel_t [NAUX-1:0]   aux_sel_i,
    input wire wblc_pkg::wblc_rsel_t [NEVD-1:0]   evd_sel_i,
    input wire logic [NB-1:0]                     work_bit_o,
    input wire logic [NAUX-1:0]                   aux_o,
    input wire logic [NEVD-1:0]                   evd_o,
    input wire logic                              dot_o,
    input wire logic                              ctl_tick_o
);
    logic [NB-1:0]   act;
    logic [NAUX-1:0] aux_x;
    logic [3:0]      v;
    logic            simple;
    logic            exp0;
    logic            evd_x;
    logic [31:0]     cnt_q;
    logic            seen_q;

    always_comb
    begin
        for (int i = 0; i < NB; i++) act[i] = op_type_i[i] inside {[3'h1:3'h4]};
        for (int i = 0; i < NAUX; i++) aux_x[i] = aux_sel_i[i] inside {[4'h1:4'h8]} && work_bit_o[aux_sel_i[i] - 4'h1];
        evd_x = work_bit_o[evd_sel_i[0] - 4'h5];
        v = in_inv_i[0] ^ {in_sel_i[0][3][0], in_sel_i[0][2][0], in_sel_i[0][1][0], in_sel_i[0][0][0]};
        simple = (in_sel_i[0][0] < 6'h02) && (in_sel_i[0][1] < 6'h02) && (in_sel_i[0][2] < 6'h02)
            && (in_sel_i[0][3] < 6'h02) && on_dly_i[0] == '0 && off_dly_i[0] == '0 && !out_inv_i[0];
        case (op_type_i[0])
            3'h1: exp0 = (v[0] & v[1]) | (v[2] & v[3]);
            3'h2: exp0 = (v[0] | v[2]) & (v[1] | v[3]);
            3'h3: exp0 = |v;
            3'h4: exp0 = &v;
            default: exp0 = 1'b0;
        endcase
    end

    // cycles since the last control tick
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= ctl_tick_o ? 32'h0 : cnt_q + 32'h1;
            seen_q <= seen_q | ctl_tick_o;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_TICK_PULSE: assert property (ctl_tick_o |=> !ctl_tick_o)
        else $error("control tick longer than one cycle");
    AST_TICK_PERIOD: assert property (ctl_tick_o && seen_q |-> cnt_q == CTRL_CYCLES - 1)
        else $error("control tick spacing wrong");
    AST_RISE_AT_TICK: assert property ((work_bit_o & ~$past(work_bit_o)) != '0 |-> $past(ctl_tick_o))
        else $error("work bit rose outside a control tick");
    AST_DOT: assert property ($past(rst_n_i) |-> dot_o == $past(|act))
        else $error("dot indicator wrong");
    AST_NONE_ZERO: assert property ($past(rst_n_i, 2) |-> (work_bit_o & ~$past(act) & ~$past(act, 2)) == '0)
        else $error("idle work bit not zero");
    AST_AUX: assert property ($past(rst_n_i) |-> aux_o == $past(aux_x))
        else $error("aux routing wrong");
    AST_EVD: assert property ($past(rst_n_i) && $past(evd_sel_i[0] inside {[4'h5:4'hc]}) |-> evd_o[0] == $past(evd_x))
        else $error("event data routing wrong");
    AST_LOGIC: assert property ($past(ctl_tick_o) && $past(rst_n_i, 2)
        && $past(simple, 2) |-> work_bit_o[0] == $past(exp0, 2))
        else $error("work bit 1 logic result wrong");

    CV_DOT: cover property ($rose(dot_o));
    CV_AUX: cover property ($rose(aux_o[0]));
    CV_WB: cover property (ctl_tick_o && work_bit_o[0]);
endmodule : wblc_props
`default_nettype wire

// >>> verification/wblc_stat_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "wblc_cfg.svh"

module wblc_stat_model
(
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [`WBLC_ST_W-1:0]    alarm_i,
    input  wire logic [`WBLC_NUM_EV-1:0]  ev_i,
    output logic [`WBLC_ST_W-1:0]         status_o,
    output logic [`WBLC_NUM_EV-1:0]       event_o
);
    logic rsv_q;

    // the reserved status bit carries no meaning, so it never sits still
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rsv_q <= 1'b0;
        else
            rsv_q <= ~rsv_q;
    end

    always_comb
    begin
        status_o     = alarm_i;
        status_o[28] = rsv_q;
        event_o      = ev_i;
    end
endmodule : wblc_stat_model
`default_nettype wire

// >>> verification/wblc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wblc_cfg.svh"

module wblc_top_bench;
    import wblc_pkg::*;
    logic                  mclk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic [3:0]            ev_q = '0;
    logic [33:0]           alm_q = '0;
    logic [3:0]            event_w;
    logic [33:0]           status_w;
    wblc_op_t  [7:0]       op_q = '0;
    wblc_sel_t [7:0][3:0]  sel_q = '0;
    logic [7:0][3:0]       inv_q = '0;
    logic [7:0]            oinv_q = '0;
    wblc_dly_t [7:0]       on_q = '0;
    wblc_dly_t [7:0]       off_q = '0;
    logic                  umin_q = 1'b0;
    wblc_rsel_t [1:0]      aux_q = '0;
    wblc_rsel_t [1:0]      evd_q = '0;
    logic [7:0]            wb_w;
    logic [1:0]            aux_w;
    logic [1:0]            evd_w;
    logic                  dot_w;
    logic                  tick_w;
    int                    mismatches = 0;
    int                    compares = 0;

    always #20 mclk_i = ~mclk_i;

    wblc_stat_model m (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .alarm_i(alm_q), .ev_i(ev_q),
        .status_o(status_w), .event_o(event_w));

    wblc_top #(.CTRL_CYCLES(8), .SEC_CYCLES(20)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .event_i(event_w), .status_i(status_w), .op_type_i(op_q), .in_sel_i(sel_q), .in_inv_i(inv_q),
        .out_inv_i(oinv_q), .on_dly_i(on_q), .off_dly_i(off_q), .unit_min_i(umin_q), .aux_sel_i(aux_q),
        .evd_sel_i(evd_q), .work_bit_o(wb_w), .aux_o(aux_w), .evd_o(evd_w), .dot_o(dot_w), .ctl_tick_o(tick_w));

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : cmp

    // returns just after the edge that follows the control tick, once the work bits are registered
    task automatic tick;
        int n;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
            if (n > 50)
            begin
                mismatches++;
                end_of_test();
            end
        end
        while (tick_w !== 1'b1);
        @(posedge mclk_i);
        #1;
    endtask : tick

    function automatic logic exp_of(input logic [2:0] op, input logic [3:0] v);
        case (op)
            3'h1: return (v[0] & v[1]) | (v[2] & v[3]);
            3'h2: return (v[0] | v[2]) & (v[1] | v[3]);
            3'h3: return |v;
            3'h4: return &v;
            default: return 1'b0;
        endcase
    endfunction : exp_of

    task automatic t_reset;
        cmp(wb_w[0], 1'b0, "held in reset");
        tick();
        cmp(wb_w[0], 1'b0, "no operation");
        cmp(wb_w[1], 1'b1, "power-up cycle on");
        cmp(dot_w, 1'b1, "dot lit");
        tick();
        cmp(wb_w[1], 1'b0, "power-up cycle over");
        @(posedge mclk_i);
        op_q[1] <= 3'h0;
    endtask : t_reset

    task automatic t_ops;
        logic [3:0] v;
        for (int op = 1; op < 8; op++)
            for (int c = 0; c < 16; c++)
            begin
                v = c[3:0];
                @(posedge mclk_i);
                op_q[0] <= op[2:0];
                inv_q[0] <= ~v;
                tick();
                tick();
                cmp(wb_w[0], exp_of(op[2:0], v), "logic result");
                cmp(dot_w, logic'(op < 5), "dot state");
            end
    endtask : t_ops

    task automatic t_status;
        @(posedge mclk_i);
        op_q[2] <= 3'h3;
        sel_q[2][0] <= 6'h0c;
        sel_q[2][1] <= `WBLC_SEL_EV_BASE;
        sel_q[2][2] <= `WBLC_SEL_RSVD;
        evd_q[1] <= `WBLC_EVD_EV_BASE;
        alm_q[5] <= 1'b1;
        tick();
        tick();
        cmp(wb_w[2], 1'b1, "status input");
        @(posedge mclk_i);
        alm_q[5] <= 1'b0;
        ev_q[0] <= 1'b1;
        tick();
        tick();
        cmp(wb_w[2], 1'b1, "event input");
        cmp(evd_w[1], 1'b1, "event data from event input");
        @(posedge mclk_i);
        ev_q[0] <= 1'b0;
        tick();
        tick();
        cmp(wb_w[2], 1'b0, "inputs off");
        cmp(evd_w[1], 1'b0, "event data off");
        @(posedge mclk_i);
        oinv_q[2] <= 1'b1;
        tick();
        cmp(wb_w[2], 1'b1, "normally closed work bit");
    endtask : t_status

    task automatic t_feed;
        @(posedge mclk_i);
        op_q[0] <= 3'h0;
        inv_q[0] <= 4'h0;
        op_q[3] <= 3'h3;
        sel_q[3][0] <= `WBLC_SEL_WB_BASE;
        aux_q[0] <= 4'h4;
        evd_q[0] <= 4'h8;
        tick();
        tick();
        @(posedge mclk_i);
        op_q[0] <= 3'h3;
        tick();
        cmp(wb_w[0], 1'b1, "source bit");
        cmp(wb_w[3], 1'b0, "feedback lags");
        tick();
        cmp(wb_w[3], 1'b1, "feedback");
        @(posedge mclk_i);
        #1;
        cmp(aux_w[0], 1'b1, "aux route");
        cmp(evd_w[0], 1'b1, "event data route");
    endtask : t_feed

    task automatic t_delay;
        @(posedge mclk_i);
        op_q[4] <= 3'h3;
        on_q[4] <= 14'h0002;
        off_q[4] <= 14'h0001;
        sel_q[4][0] <= `WBLC_SEL_ON;
        repeat (2) tick();
        cmp(wb_w[4], 1'b0, "on delay holds");
        repeat (6) tick();
        cmp(wb_w[4], 1'b1, "on delay ends");
        @(posedge mclk_i);
        sel_q[4][0] <= `WBLC_SEL_OFF;
        tick();
        cmp(wb_w[4], 1'b1, "off delay holds");
        repeat (4) tick();
        cmp(wb_w[4], 1'b0, "off delay ends");
        @(posedge mclk_i);
        umin_q <= 1'b1;
        sel_q[4][0] <= `WBLC_SEL_ON;
        repeat (8) tick();
        cmp(wb_w[4], 1'b0, "minute delay holds");
        repeat (300) tick();
        cmp(wb_w[4], 1'b1, "minute delay ends");
    endtask : t_delay

    initial
    begin
        sel_q[0] = {4{`WBLC_SEL_ON}};
        sel_q[1][0] = `WBLC_SEL_FIRST;
        op_q[1] = 3'h3;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_ops();
        t_status();
        t_feed();
        t_delay();
        end_of_test();
    end
endmodule : wblc_top_bench

bind wblc_top wblc_props #(.NB(NB), .NAUX(NAUX), .NEVD(NEVD), .CTRL_CYCLES(CTRL_CYCLES), .SEC_CYCLES(SEC_CYCLES))
    u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .event_i(event_i), .status_i(status_i), .op_type_i(op_type_i),
    .in_sel_i(in_sel_i), .in_inv_i(in_inv_i), .out_inv_i(out_inv_i), .on_dly_i(on_dly_i), .off_dly_i(off_dly_i),
    .unit_min_i(unit_min_i), .aux_sel_i(aux_sel_i), .evd_sel_i(evd_sel_i), .work_bit_o(work_bit_o),
    .aux_o(aux_o), .evd_o(evd_o), .dot_o(dot_o), .ctl_tick_o(ctl_tick_o));
`default_nettype wire
